// ### rtl/umf_uart_regs.sv
`timescale 1ns/1ps
`include "umf_defines.svh"

module umf_uart_regs #(
    parameter int RX_FIFO_DEPTH = 2
) (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_n_i,
    input  wire logic [3:0]            avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [31:0]           avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic      [31:0]           avs_readdata_o,
    output logic                       avs_waitrequest_o,
    input  wire umf_pkg::umf_rx_frame_s rx_frame_i,
    input  wire logic                  rx_frame_valid_i,
    input  wire logic                  rx_start_i,
    output logic      [8:0]            tx_frame_o,
    output logic                       tx_load_o,
    input  wire logic                  tx_shift_empty_i,
    input  wire logic                  tx_done_i,
    input  wire logic                  global_irq_enable_i,
    input  wire logic                  tx_complete_irq_ack_i,
    output logic                       rx_complete_irq_o,
    output logic                       tx_complete_irq_o,
    output logic                       tx_empty_irq_o,
    output logic                       rx_pin_override_o,
    output logic                       tx_pin_override_o,
    output umf_pkg::umf_cfg_s          cfg_o,
    output logic      [4:0]            baud_divisor_o
);
    import umf_pkg::*;

    // the entry shuffle below is written for exactly two entries
    if (RX_FIFO_DEPTH != 2) begin : g_depth_check
        $error("umf_uart_regs: RX_FIFO_DEPTH must be 2");
    end

    // register state
    logic                filt_reg;
    logic                dbl_reg;
    logic [7:0]          ctrl_b_reg;
    logic [6:0]          ctrl_c_reg;
    logic                txen_eff_reg;
    logic                tx_buf_valid_reg;
    logic [8:0]          tx_buf_reg;
    logic                txc_reg;
    umf_rx_entry_s       entry_reg [RX_FIFO_DEPTH];
    logic [1:0]          count_reg;
    logic                hold_valid_reg;
    umf_rx_entry_s       hold_reg;
    logic                dor_reg;
    logic                ack_reg;
    logic [31:0]         readdata_reg;

    // next values of the receive side
    umf_rx_entry_s       entry_next [RX_FIFO_DEPTH];
    logic [1:0]          count_next;
    logic                hold_valid_next;
    umf_rx_entry_s       hold_next;

    // bus decode: one wait state, request acts on the edge where waitrequest is low
    logic                bus_req;
    logic                sel_data;
    logic                sel_a;
    logic                sel_b;
    logic                sel_c;
    logic                wr_acc;
    logic                rd_data_acc;
    logic                wr_data_acc;
    assign bus_req           = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req & ~ack_reg;
    assign sel_data          = (avs_address_i == `UMF_OFS_DATA);
    assign sel_a             = (avs_address_i == `UMF_OFS_STAT_A);
    assign sel_b             = (avs_address_i == `UMF_OFS_CTRL_B);
    assign sel_c             = (avs_address_i == `UMF_OFS_CTRL_C);
    assign wr_acc            = avs_write_i & ack_reg & avs_byteenable_i[0];
    assign rd_data_acc       = avs_read_i & ack_reg & sel_data;
    assign wr_data_acc       = wr_acc & sel_data;

    // line format decode
    logic [2:0]          csz;
    logic                nine_bit;
    logic                rxen;
    logic                sync_mode;
    logic [7:0]          data_mask;
    assign csz       = {ctrl_b_reg[`UMF_B_CSZ2], ctrl_c_reg[2:1]};
    assign nine_bit  = (csz == UMF_CSZ_9);
    assign rxen      = ctrl_b_reg[`UMF_B_RXEN];
    assign sync_mode = ctrl_c_reg[`UMF_C_MSEL];

    always_comb begin
        case (csz)
            UMF_CSZ_5: data_mask = 8'h1f;
            UMF_CSZ_6: data_mask = 8'h3f;
            UMF_CSZ_7: data_mask = 8'h7f;
            default:   data_mask = 8'hff; // reserved codes behave as 8 bits
        endcase
    end

    // incoming frame: type bit, filter decision and the entry it would become
    logic                frame_type;
    logic                rx_keep;
    umf_rx_entry_s       rx_new;
    assign frame_type = nine_bit ? rx_frame_i.data[8] : rx_frame_i.stop1;
    assign rx_keep    = rx_frame_valid_i & rxen & ~(filt_reg & ~frame_type);
    assign rx_new.data       = {rx_frame_i.data[8] & nine_bit, rx_frame_i.data[7:0] & data_mask};
    assign rx_new.frame_err  = ~rx_frame_i.stop1;
    assign rx_new.parity_err = rx_frame_i.parity_bad & ctrl_c_reg[`UMF_C_PEN];

    // flag follows count; pop first, then held character, then new one
    logic                pop;
    logic                rx_complete;
    assign pop         = rd_data_acc & (count_reg != 2'd0);
    assign rx_complete = (count_reg != 2'd0);

    always_comb begin
        entry_next      = entry_reg;
        count_next      = count_reg;
        hold_valid_next = hold_valid_reg;
        hold_next       = hold_reg;
        if (pop) begin
            entry_next[0] = entry_reg[1];
            count_next    = count_reg - 2'd1;
        end
        if (hold_valid_next && count_next != 2'd2) begin
            entry_next[count_next[0]] = hold_reg;
            count_next                = count_next + 2'd1;
            hold_valid_next           = 1'b0;
        end
        if (rx_keep) begin
            if (count_next != 2'd2) begin
                entry_next[count_next[0]] = rx_new;
                count_next                = count_next + 2'd1;
            end else begin
                hold_next       = rx_new; // waits in the shift register stage
                hold_valid_next = 1'b1;
            end
        end
        if (!rxen) begin
            count_next      = 2'd0;
            hold_valid_next = 1'b0;
        end
    end

    // receive buffer registers
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            entry_reg[0]   <= '0;
            entry_reg[1]   <= '0;
            count_reg      <= 2'd0;
            hold_valid_reg <= 1'b0;
            hold_reg       <= '0;
        end else begin
            entry_reg      <= entry_next;
            count_reg      <= count_next;
            hold_valid_reg <= hold_valid_next;
            hold_reg       <= hold_next;
        end
    end

    logic                dor_set;
    assign dor_set = rx_start_i & rxen & (count_reg == 2'd2) & hold_valid_reg;

    // overrun flag: a new overrun wins over the read that would clear it
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dor_reg <= 1'b0;
        end else if (!rxen) begin
            dor_reg <= 1'b0;
        end else if (dor_set) begin
            dor_reg <= 1'b1;
        end else if (rd_data_acc) begin
            dor_reg <= 1'b0;
        end
    end

    // transmit side handshake
    logic                tx_accept;
    logic                txc_set;
    logic                txc_clr;
    assign tx_accept = wr_data_acc & ~tx_buf_valid_reg;
    assign tx_load_o = tx_buf_valid_reg & txen_eff_reg & tx_shift_empty_i;
    assign txc_set   = tx_done_i & ~tx_buf_valid_reg;
    assign txc_clr   = (wr_acc & sel_a & avs_writedata_i[`UMF_A_TXC]) | tx_complete_irq_ack_i;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_buf_valid_reg <= 1'b0;
            tx_buf_reg       <= 9'h000;
        end else if (tx_accept) begin
            tx_buf_valid_reg <= 1'b1;
            // ninth bit taken from control b at the data write
            tx_buf_reg       <= {ctrl_b_reg[`UMF_B_TX9] & nine_bit,
                                 avs_writedata_i[7:0] & data_mask};
        end else if (tx_load_o) begin
            tx_buf_valid_reg <= 1'b0;
        end
    end
    assign tx_frame_o = tx_buf_reg;

    // transmit complete flag: set wins over clear
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            txc_reg <= 1'b0;
        end else if (txc_set) begin
            txc_reg <= 1'b1;
        end else if (txc_clr) begin
            txc_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            txen_eff_reg <= 1'b0;
        end else if (ctrl_b_reg[`UMF_B_TXEN]) begin
            txen_eff_reg <= 1'b1;
        end else if (!tx_buf_valid_reg && tx_shift_empty_i) begin
            txen_eff_reg <= 1'b0;
        end
    end

    // software-written control bits; the error flags take no write
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            filt_reg   <= 1'b0;
            dbl_reg    <= 1'b0;
            ctrl_b_reg <= `UMF_RST_CTRL_B;
            ctrl_c_reg <= `UMF_RST_CTRL_C;
        end else if (wr_acc) begin
            if (sel_a) begin
                filt_reg <= avs_writedata_i[`UMF_A_FILT];
                dbl_reg  <= avs_writedata_i[`UMF_A_U2X];
            end
            if (sel_b) begin
                ctrl_b_reg <= avs_writedata_i[7:0] & `UMF_B_WMASK;
            end
            if (sel_c) begin
                ctrl_c_reg <= avs_writedata_i[6:0];
            end
        end
    end

    // read mux; head flags are masked when nothing is buffered
    logic [7:0]          stat_a_val;
    logic [7:0]          ctrl_b_val;
    logic [31:0]         rd_mux;
    umf_rx_entry_s       head;
    assign head       = entry_reg[0];
    assign stat_a_val = {rx_complete, txc_reg, ~tx_buf_valid_reg,
                         head.frame_err & rx_complete, dor_reg,
                         head.parity_err & rx_complete, dbl_reg, filt_reg};
    assign ctrl_b_val = {ctrl_b_reg[7:2], head.data[8] & rx_complete, ctrl_b_reg[0]};
    assign rd_mux     = sel_data ? {24'h000000, head.data[7:0] & {8{rx_complete}}} :
                        sel_a    ? {24'h000000, stat_a_val} :
                        sel_b    ? {24'h000000, ctrl_b_val} :
                        sel_c    ? {25'h0000000, ctrl_c_reg} : 32'h00000000;

    // bus answer: read data captured in the wait cycle, stable at the accept edge
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_reg      <= 1'b0;
            readdata_reg <= 32'h00000000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            if (avs_read_i && !ack_reg) begin
                readdata_reg <= rd_mux;
            end
        end
    end
    assign avs_readdata_o = readdata_reg;

    assign rx_complete_irq_o = ctrl_b_reg[`UMF_B_RXCIE] & global_irq_enable_i & rx_complete;
    assign tx_complete_irq_o = ctrl_b_reg[`UMF_B_TXCIE] & global_irq_enable_i & txc_reg;
    assign tx_empty_irq_o    = ctrl_b_reg[`UMF_B_UDRIE] & global_irq_enable_i & ~tx_buf_valid_reg;

    assign rx_pin_override_o = rxen;
    assign tx_pin_override_o = txen_eff_reg;

    // line format and divisor to the serial engines; filter bit never reaches this side
    assign cfg_o.char_size   = csz;
    assign cfg_o.parity_mode = ctrl_c_reg[5:4];
    assign cfg_o.two_stop    = ctrl_c_reg[`UMF_C_SBS];
    assign cfg_o.sync_mode   = sync_mode;
    assign cfg_o.clock_pol   = ctrl_c_reg[0];
    assign baud_divisor_o    = (dbl_reg && !sync_mode) ? `UMF_DIV_DOUBLE : `UMF_DIV_NORMAL;

    // checks on the block's own behaviour
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    property p_filter_drop;
        rx_frame_valid_i && rxen && filt_reg && !frame_type && !pop && !hold_valid_reg
            |=> count_reg == $past(count_reg);
    endproperty
    a_filter_drop: assert property (p_filter_drop)
        else $error("filtered data frame entered the buffer");

    property p_addr_stored;
        rx_keep && count_reg == 2'd0 |=> rx_complete ##0 head.data[7:0] == $past(rx_new.data[7:0]);
    endproperty
    a_addr_stored: assert property (p_addr_stored)
        else $error("accepted frame not stored at head");

    property p_full_write_ignored;
        wr_data_acc && tx_buf_valid_reg && !tx_load_o |=> tx_buf_reg == $past(tx_buf_reg);
    endproperty
    a_full_write_ignored: assert property (p_full_write_ignored)
        else $error("write accepted while buffer full");

    property p_pop_two;
        rd_data_acc && count_reg == 2'd2 && !hold_valid_reg && !rx_keep && rxen
            |=> count_reg == 2'd1;
    endproperty
    a_pop_two: assert property (p_pop_two)
        else $error("read did not advance the receive buffer");

    property p_flush;
        !rxen |=> !rx_complete && !dor_reg && !hold_valid_reg;
    endproperty
    a_flush: assert property (p_flush)
        else $error("disabled receiver kept data or flags");

    property p_txc_set;
        tx_done_i && !tx_buf_valid_reg |=> txc_reg;
    endproperty
    a_txc_set: assert property (p_txc_set)
        else $error("transmit complete not set");

    property p_overrun;
        dor_set |=> dor_reg;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged");

    property p_divisor;
        dbl_reg && !sync_mode |-> baud_divisor_o == 5'h08;
    endproperty
    a_divisor: assert property (p_divisor)
        else $error("double speed divisor wrong");

    property p_tx_disable_wait;
        !ctrl_b_reg[`UMF_B_TXEN] && tx_buf_valid_reg && txen_eff_reg |=> tx_pin_override_o;
    endproperty
    a_tx_disable_wait: assert property (p_tx_disable_wait)
        else $error("transmitter released pin with data pending");

    property p_size_mask;
        avs_read_i && !ack_reg && sel_data && csz == UMF_CSZ_5 |=> avs_readdata_o[7:5] == 3'b000;
    endproperty
    a_size_mask: assert property (p_size_mask)
        else $error("unused upper bits not zero");

    c_filtered: cover property (rx_frame_valid_i && rxen && filt_reg && !frame_type);
    c_overrun: cover property (dor_set);
    c_txc: cover property (txc_set);
    c_pop_full: cover property (pop && count_reg == 2'd2);

endmodule // umf_uart_regs

// ### rtl/umf_defines.svh
`ifndef UMF_DEFINES_SVH
`define UMF_DEFINES_SVH

// register byte offsets on the avalon slave
`define UMF_OFS_DATA      4'h0
`define UMF_OFS_STAT_A    4'h4
`define UMF_OFS_CTRL_B    4'h8
`define UMF_OFS_CTRL_C    4'hc

// serial_status_control_a field positions
`define UMF_A_RXC         7
`define UMF_A_TXC         6
`define UMF_A_UDRE        5
`define UMF_A_FE          4
`define UMF_A_DOR         3
`define UMF_A_PE          2
`define UMF_A_U2X         1
`define UMF_A_FILT        0

// serial_control_b field positions
`define UMF_B_RXCIE       7
`define UMF_B_TXCIE       6
`define UMF_B_UDRIE       5
`define UMF_B_RXEN        4
`define UMF_B_TXEN        3
`define UMF_B_CSZ2        2
`define UMF_B_RX9         1
`define UMF_B_TX9         0

// serial_control_c field positions
`define UMF_C_MSEL        6
`define UMF_C_PEN         5
`define UMF_C_SBS         3

// reset values and divisors
`define UMF_RST_CTRL_B    8'h00
`define UMF_RST_CTRL_C    7'h06
`define UMF_B_WMASK       8'hfd
`define UMF_DIV_NORMAL    5'h10
`define UMF_DIV_DOUBLE    5'h08

`endif

// ### rtl/umf_pkg.sv
package umf_pkg;

    // character size codes, high bit from control b, low bits from control c
    typedef enum logic [2:0] {
        UMF_CSZ_5 = 3'b000,
        UMF_CSZ_6 = 3'b001,
        UMF_CSZ_7 = 3'b010,
        UMF_CSZ_8 = 3'b011,
        UMF_CSZ_9 = 3'b111
    } umf_csz_e;

    // one frame handed over by the receive sampler
    typedef struct packed {
        logic [8:0] data;
        logic       stop1;
        logic       parity_bad;
    } umf_rx_frame_s;

    // one receive buffer entry with its own error flags
    typedef struct packed {
        logic [8:0] data;
        logic       frame_err;
        logic       parity_err;
    } umf_rx_entry_s;

    // line format handed to the serial engines
    typedef struct packed {
        logic [2:0] char_size;
        logic [1:0] parity_mode;
        logic       two_stop;
        logic       sync_mode;
        logic       clock_pol;
    } umf_cfg_s;

endpackage

// ### verif/umf_line_model.sv
`timescale 1ns/1ps
// far side: a peer node on the shared line, seen through the sampler port,
// and a shifter that stays busy for a fixed time after every load
module umf_line_model #(
    parameter int BUSY_CYCLES = 20
) (
    input  wire logic    mclk_i,
    input  wire logic    rst_n_i,
    input  wire logic    tx_load_i,
    output umf_pkg::umf_rx_frame_s rx_frame_o,
    output logic         rx_frame_valid_o,
    output logic         rx_start_o,
    output logic         tx_shift_empty_o,
    output logic         tx_done_o
);
    import umf_pkg::*;
    int cnt;

    initial begin
        rx_frame_o = '0;
        rx_frame_valid_o = 1'b0;
        rx_start_o = 1'b0;
    end

    // one frame or start pulse per call; the bus shows the inverse afterwards
    // so a stale value can never pass for a new frame
    // type bit carried
    task automatic send(input umf_rx_frame_s f, input logic v, input logic s);
        @(posedge mclk_i);
        rx_frame_o <= f;
        rx_frame_valid_o <= v;
        rx_start_o <= s;
        @(posedge mclk_i);
        rx_frame_o <= ~f;
        rx_frame_valid_o <= 1'b0;
        rx_start_o <= 1'b0;
    endtask

    // shifter goes busy the edge after a load, done pulses as it frees up
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 0;
            tx_shift_empty_o <= 1'b1;
            tx_done_o <= 1'b0;
        end else begin
            tx_done_o <= 1'b0;
            if (tx_load_i) begin
                tx_shift_empty_o <= 1'b0;
                cnt <= BUSY_CYCLES;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
                tx_shift_empty_o <= (cnt == 1);
                tx_done_o <= (cnt == 1);
            end
        end
    end
endmodule // umf_line_model

// ### verif/uart_multidrop_filter_and_regs_tb.sv
`timescale 1ns/1ps
// register-bus driver with expectation queues for the multidrop serial block
module uart_multidrop_filter_and_regs_tb;
    import umf_pkg::*;
    logic          mclk_i           = 1'b0;
    logic          rst_n_i          = 1'b0;
    logic [3:0]    avs_address_i    = 4'h0;
    logic          avs_read_i       = 1'b0;
    logic          avs_write_i      = 1'b0;
    logic [31:0]   avs_writedata_i  = 32'h0;
    logic [3:0]    avs_byteenable_i = 4'hf;
    logic          glob_en          = 1'b0;
    logic          ack              = 1'b0;
    logic [31:0]   avs_readdata_o;
    logic          avs_waitrequest_o;
    logic          tx_load_o, tx_shift_empty_i, tx_done_i, rx_frame_valid_i, rx_start_i;
    logic          irq_rx, irq_tx, irq_empty, rx_ovr, tx_ovr;
    logic [8:0]    tx_frame_o;
    logic [4:0]    baud_divisor_o;
    umf_rx_frame_s rx_frame_i;
    umf_cfg_s      cfg_o;
    logic [31:0]   rq[$];
    logic [31:0]   tq[$];
    logic [31:0]   seed = 32'hcdbd7f50;
    logic [7:0]    r1, r2, r3;
    int            failures = 0;
    int            n_compared = 0;

    always #5 mclk_i = ~mclk_i;

    umf_uart_regs i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .rx_frame_i(rx_frame_i),
        .rx_frame_valid_i(rx_frame_valid_i), .rx_start_i(rx_start_i), .tx_frame_o(tx_frame_o),
        .tx_load_o(tx_load_o), .tx_shift_empty_i(tx_shift_empty_i), .tx_done_i(tx_done_i),
        .global_irq_enable_i(glob_en), .tx_complete_irq_ack_i(ack),
        .rx_complete_irq_o(irq_rx), .tx_complete_irq_o(irq_tx), .tx_empty_irq_o(irq_empty),
        .rx_pin_override_o(rx_ovr), .tx_pin_override_o(tx_ovr), .cfg_o(cfg_o),
        .baud_divisor_o(baud_divisor_o));

    umf_line_model i_line (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .tx_load_i(tx_load_o),
        .rx_frame_o(rx_frame_i), .rx_frame_valid_o(rx_frame_valid_i), .rx_start_o(rx_start_i),
        .tx_shift_empty_o(tx_shift_empty_i), .tx_done_o(tx_done_i));

    // lfsr step, low byte used as payload
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one bus cycle: hold everything until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= {24'h0, d};
        // no local limit: only the watchdog ends a hung wait
        do begin
            @(posedge mclk_i);
        end while (avs_waitrequest_o !== 1'b0);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        rq.push_back({24'h0, e});
        bus(1'b0, a, 8'h0);
    endtask

    task automatic wait_done();
        do begin
            @(posedge mclk_i);
        end while (tx_done_i !== 1'b1);
    endtask

    // monitor: each completed read or shifter load takes the oldest note
    always @(posedge mclk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0) chk(avs_readdata_o, rq.pop_front());
        if (tx_load_o === 1'b1) chk({23'h0, tx_frame_o}, tq.pop_front());
    end

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(4'h4, 8'h20);
        rd(4'h8, 8'h00);
        rd(4'hc, 8'h06);
        bus(1'b1, 4'h2, 8'hff);
        rd(4'h2, 8'h00);
        avs_byteenable_i <= 4'h0;
        bus(1'b1, 4'hc, 8'hff);
        avs_byteenable_i <= 4'hf;
        rd(4'hc, 8'h06);
        $display("test reset done");
        // 9-bit, filter on: ninth bit is the frame type
        bus(1'b1, 4'h8, 8'h1c);
        bus(1'b1, 4'h4, 8'h01);
        r1 = rnd();
        i_line.send({1'b0, rnd(), 1'b1, 1'b0}, 1'b1, 1'b0);
        i_line.send({1'b1, r1, 1'b1, 1'b0}, 1'b1, 1'b0);
        rd(4'h4, 8'ha1);
        rd(4'h8, 8'h1e);
        rd(4'h0, r1);
        rd(4'h4, 8'h21);
        // addressed slave drops its filter for the data
        bus(1'b1, 4'h4, 8'h00);
        r2 = rnd();
        i_line.send({1'b0, r2, 1'b1, 1'b0}, 1'b1, 1'b0);
        rd(4'h8, 8'h1c);
        rd(4'h0, r2);
        // 5-bit, filter on: first stop bit is the type, upper bits read zero
        bus(1'b1, 4'h8, 8'h18);
        bus(1'b1, 4'hc, 8'h00);
        bus(1'b1, 4'h4, 8'h01);
        i_line.send({9'h0ff, 1'b0, 1'b0}, 1'b1, 1'b0);
        i_line.send({9'h1ff, 1'b1, 1'b0}, 1'b1, 1'b0);
        rd(4'h4, 8'ha1);
        rd(4'h0, 8'h1f);
        rd(4'h4, 8'h21);
        $display("test filter done");
        // per-entry errors, overrun, then flush by receiver disable
        bus(1'b1, 4'h4, 8'h00);
        bus(1'b1, 4'hc, 8'h26);
        r1 = rnd();
        r2 = rnd();
        r3 = rnd();
        i_line.send({1'b0, r1, 1'b0, 1'b0}, 1'b1, 1'b0);
        i_line.send({1'b0, r2, 1'b1, 1'b1}, 1'b1, 1'b0);
        i_line.send({1'b0, r3, 1'b1, 1'b0}, 1'b1, 1'b0);
        i_line.send({1'b0, r3, 1'b1, 1'b0}, 1'b0, 1'b1);
        rd(4'h4, 8'hb8);
        rd(4'h0, r1);
        rd(4'h4, 8'ha4);
        rd(4'h0, r2);
        bus(1'b1, 4'h8, 8'h08);
        rd(4'h4, 8'h20);
        rd(4'h0, 8'h00);
        chk(rx_ovr, 1'b0);
        $display("test errors done");
        // transmit: busy shifter, full buffer, refused write, filter on
        bus(1'b1, 4'hc, 8'h06);
        bus(1'b1, 4'h8, 8'h0d);
        bus(1'b1, 4'h4, 8'h01);
        r1 = rnd();
        r2 = rnd();
        tq.push_back({23'h0, 1'b1, r1});
        bus(1'b1, 4'h0, r1);
        tq.push_back({23'h0, 1'b1, r2});
        bus(1'b1, 4'h0, r2);
        bus(1'b1, 4'h0, rnd());
        rd(4'h4, 8'h01);
        wait_done();
        wait_done();
        rd(4'h4, 8'h61);
        chk(irq_tx, 1'b0);
        bus(1'b1, 4'h8, 8'h4d);
        @(posedge mclk_i);
        glob_en <= 1'b1;
        @(negedge mclk_i);
        chk(irq_tx, 1'b1);
        @(posedge mclk_i);
        ack <= 1'b1;
        @(posedge mclk_i);
        ack <= 1'b0;
        rd(4'h4, 8'h21);
        bus(1'b1, 4'h8, 8'h2d);
        @(negedge mclk_i);
        chk(irq_empty, 1'b1);
        chk(tq.size(), 32'h0);
        $display("test transmit done");
        // disable while busy keeps the pin until the shifter drains
        bus(1'b1, 4'h4, 8'h00);
        r1 = rnd();
        r2 = rnd();
        tq.push_back({23'h0, 1'b1, r1});
        bus(1'b1, 4'h0, r1);
        // second word waits in the buffer while the disable arrives
        tq.push_back({23'h0, 1'b1, r2});
        bus(1'b1, 4'h0, r2);
        bus(1'b1, 4'h8, 8'h05);
        @(negedge mclk_i);
        chk(tx_ovr, 1'b1);
        wait_done();
        @(negedge mclk_i);
        chk(tx_ovr, 1'b1);
        wait_done();
        repeat (2) @(posedge mclk_i);
        chk(tx_ovr, 1'b0);
        // speed, mode and stop select
        bus(1'b1, 4'h4, 8'h02);
        @(negedge mclk_i);
        chk(baud_divisor_o, 32'h8);
        bus(1'b1, 4'hc, 8'h4e);
        @(negedge mclk_i);
        chk(baud_divisor_o, 32'h10);
        chk({cfg_o.sync_mode, cfg_o.two_stop}, 32'h3);
        chk(cfg_o, 32'he6);
        // receive interrupt needs a buffered character
        bus(1'b1, 4'h8, 8'h90);
        @(negedge mclk_i);
        chk(irq_rx, 1'b0);
        i_line.send({1'b0, rnd(), 1'b1, 1'b0}, 1'b1, 1'b0);
        @(negedge mclk_i);
        chk(irq_rx, 1'b1);
        $display("test config done");
        conclude();
    end
endmodule // uart_multidrop_filter_and_regs_tb
